/* design/opcode_field_map.svh */
// Purpose: constants for the instruction field decoder
// Assumes: included by bare name
// Notes: definitions only
`ifndef OPCODE_FIELD_MAP_SVH
`define OPCODE_FIELD_MAP_SVH

`define DIR_BIT 1
`define WIDEN_BIT 0
`define SIZE_BIT 0
`define NEG_BIT 0
`define COND_MSB 3
`define COND_LSB 1
`define SIGN8_BIT 7
`define SIGN16_BIT 15

`define FLAG_CF 0
`define FLAG_PF 1
`define FLAG_ZF 2
`define FLAG_SF 3
`define FLAG_OF 4

`define CC_OVERFLOW 3'h0
`define CC_BELOW 3'h1
`define CC_EQUAL 3'h2
`define CC_BELOW_EQ 3'h3
`define CC_SIGN 3'h4
`define CC_PARITY 3'h5
`define CC_LESS 3'h6
`define CC_LESS_EQ 3'h7

`define SEL_0 3'h0
`define SEL_1 3'h1
`define SEL_2 3'h2
`define SEL_3 3'h3
`define SEL_6 3'h6
`define SEL_7 3'h7

`define GRP_CTRL 2'h0
`define GRP_DEBUG 2'h1
`define GRP_TEST 2'h2

`endif

/* design/opcode_field_pkg.sv */
// Purpose: shared types for the instruction field decoder
// Assumes: nothing
// Notes: numbers live in the map header
package opcode_field_pkg;

  // size of the immediate as fetched and of the destination
  typedef enum logic [1:0] {
    SZ_8 = 2'b00,
    SZ_16 = 2'b01,
    SZ_32 = 2'b10
  } op_size_t;

  // special register picked by a move
  typedef enum logic [3:0] {
    SR_NONE = 4'b0000,
    SR_CONTROL_ZERO = 4'b0001,
    SR_FAULT_ADDRESS = 4'b0010,
    SR_PAGE_DIR_BASE = 4'b0011,
    SR_BREAK0 = 4'b0100,
    SR_BREAK1 = 4'b0101,
    SR_BREAK2 = 4'b0110,
    SR_BREAK3 = 4'b0111,
    SR_DEBUG_STATUS = 4'b1000,
    SR_DEBUG_CONTROL = 4'b1001,
    SR_TLB_COMMAND = 4'b1010,
    SR_TLB_DATA = 4'b1011
  } special_reg_t;

  // decoder pipeline state
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_OUT = 1'b1
  } dec_state_t;

endpackage : opcode_field_pkg

/* design/cond_flags_if.sv */
// Purpose: carries flags and condition field to the condition evaluator
// Assumes: single clock domain
// Notes: combinational link between the two modules
`timescale 1ns/100ps
`default_nettype none

interface cond_flags_if;
  logic [3:0] tttn;
  logic cf;
  logic pf;
  logic zf;
  logic sf;
  logic of;
  logic taken;

  modport decoder (output tttn, cf, pf, zf, sf, of, input taken);
  modport evaluator (input tttn, cf, pf, zf, sf, of, output taken);
endinterface : cond_flags_if

`default_nettype wire

/* design/cond_evaluator.sv */
// Purpose: evaluates the four-bit condition field against the flags
// Assumes: flags are stable while the field is presented
// Notes: purely combinational, result is registered by the caller
`timescale 1ns/100ps
`default_nettype none
`include "opcode_field_map.svh"

module cond_evaluator (
  cond_flags_if.evaluator cf_if
);
  import opcode_field_pkg::*;

  // -----------------------------------------------------------------
  // condition select and polarity
  // -----------------------------------------------------------------
  logic base;

  // upper three bits pick the test, low bit inverts it
  always_comb begin
    base = 1'b0;
    case (cf_if.tttn[`COND_MSB:`COND_LSB])
      `CC_OVERFLOW: base = cf_if.of;
      `CC_BELOW: base = cf_if.cf;
      `CC_EQUAL: base = cf_if.zf;
      `CC_BELOW_EQ: base = cf_if.cf | cf_if.zf;
      `CC_SIGN: base = cf_if.sf;
      `CC_PARITY: base = cf_if.pf;
      `CC_LESS: base = cf_if.sf ^ cf_if.of;
      `CC_LESS_EQ: base = (cf_if.sf ^ cf_if.of) | cf_if.zf;
      default: base = 1'b0;
    endcase
  end

  assign cf_if.taken = base ^ cf_if.tttn[`NEG_BIT];

endmodule : cond_evaluator

`default_nettype wire

/* design/opcode_field_decoder.sv */
// Purpose: decodes direction, sign-extend, condition and special
//          register fields of fetched instruction bytes
// Assumes: one request per VALID pulse, outputs one cycle later
// Notes: all outputs are registered
//
// Overview of operation
// - direction bit 0 makes reg the source and r/m the destination, 1 swaps them.
// - with the widen flag set, a byte immediate going to a 16 or 32 bit target is sign-extended.
// - with the widen flag clear, or a wide immediate, the immediate passes unchanged.
// - the top three condition bits pick the test and the low bit negates it.
// - condition codes map to overflow, below, equal, below-or-equal, sign, parity, less, less-or-equal.
// - the condition is evaluated for conditional jumps and set-on-condition against the flags.
// - control group codes 000, 010, 011 pick control zero, fault address and page directory base.
// - debug group codes 000 to 011 pick breakpoints, 110 debug status, 111 debug control.
// - test group codes 110 and 111 pick translation test command and data.
// - a register code picks byte registers when size bit is 0, full registers when 1.
`timescale 1ns/100ps
`default_nettype none
`include "opcode_field_map.svh"

module opcode_field_decoder (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic VALID,
  input wire logic [7:0] OPCODE,
  input wire logic [2:0] REG_FIELD,
  input wire logic [2:0] RM_FIELD,
  input wire logic [3:0] TTTN,
  input wire logic IS_COND,
  input wire logic [31:0] IMM_IN,
  input wire opcode_field_pkg::op_size_t IMM_SIZE,
  input wire opcode_field_pkg::op_size_t DEST_SIZE,
  input wire logic IS_SPECIAL,
  input wire logic [1:0] SPECIAL_GROUP,
  input wire logic [2:0] SPECIAL_CODE,
  input wire logic [5:0] FLAGS,
  output logic OUT_VALID,
  output logic [2:0] SRC_REG,
  output logic [2:0] DST_REG,
  output logic RM_IS_DEST,
  output logic BYTE_REG,
  output logic [31:0] IMM_OUT,
  output logic COND_TRUE,
  output opcode_field_pkg::special_reg_t SPECIAL_SEL,
  output logic INVALID_OP
);
  import opcode_field_pkg::*;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // sign-extend a byte to the destination width
  function automatic logic [31:0] widen8(input logic [7:0] b,
                                         input op_size_t dsz);
    logic [31:0] r;
    r = {24'h000000, b};
    if (dsz == SZ_16) begin
      r = {16'h0000, {8{b[`SIGN8_BIT]}}, b};
    end else if (dsz == SZ_32) begin
      r = {{24{b[`SIGN8_BIT]}}, b};
    end
    return r;
  endfunction : widen8

  // -----------------------------------------------------------------
  // condition evaluator link; flags ordered cf,pf,zf,sf,of in FLAGS
  // -----------------------------------------------------------------
  cond_flags_if cfl ();
  assign cfl.tttn = TTTN;
  assign cfl.cf = FLAGS[`FLAG_CF];
  assign cfl.pf = FLAGS[`FLAG_PF];
  assign cfl.zf = FLAGS[`FLAG_ZF];
  assign cfl.sf = FLAGS[`FLAG_SF];
  assign cfl.of = FLAGS[`FLAG_OF];

  cond_evaluator u_eval (
    .cf_if(cfl.evaluator)
  );

  // -----------------------------------------------------------------
  // next-value logic
  // -----------------------------------------------------------------
  dec_state_t state_reg, state_next;
  logic [2:0] src_reg, src_next, dst_reg, dst_next;
  logic rm_dest_reg, rm_dest_next, byte_reg, byte_next;
  logic [31:0] imm_reg, imm_next;
  logic cond_reg, cond_next, inv_reg, inv_next;
  special_reg_t sel_reg, sel_next;

  always_comb begin
    state_next = VALID ? ST_OUT : ST_IDLE;
    src_next = src_reg;
    dst_next = dst_reg;
    rm_dest_next = rm_dest_reg;
    byte_next = byte_reg;
    imm_next = imm_reg;
    cond_next = cond_reg;
    inv_next = 1'b0;
    sel_next = SR_NONE;
    if (VALID) begin
      // direction: 0 writes r/m from reg, 1 writes reg from r/m
      if (OPCODE[`DIR_BIT]) begin
        src_next = RM_FIELD;
        dst_next = REG_FIELD;
      end else begin
        src_next = REG_FIELD;
        dst_next = RM_FIELD;
      end
      rm_dest_next = ~OPCODE[`DIR_BIT];
      byte_next = ~OPCODE[`SIZE_BIT];
      // only a byte immediate into a wider target is widened
      if (OPCODE[`WIDEN_BIT] && IMM_SIZE == SZ_8 && DEST_SIZE != SZ_8)
      begin
        imm_next = widen8(IMM_IN[7:0], DEST_SIZE);
      end else begin
        imm_next = IMM_IN;
      end
      cond_next = IS_COND ? cfl.taken : 1'b0;
      if (IS_SPECIAL) begin
        // unlisted codes select nothing and flag invalid opcode
        inv_next = 1'b1;
        if (SPECIAL_GROUP == `GRP_CTRL) begin
          case (SPECIAL_CODE)
            `SEL_0: sel_next = SR_CONTROL_ZERO;
            `SEL_2: sel_next = SR_FAULT_ADDRESS;
            `SEL_3: sel_next = SR_PAGE_DIR_BASE;
            default: sel_next = SR_NONE;
          endcase
        end else if (SPECIAL_GROUP == `GRP_DEBUG) begin
          case (SPECIAL_CODE)
            `SEL_0: sel_next = SR_BREAK0;
            `SEL_1: sel_next = SR_BREAK1;
            `SEL_2: sel_next = SR_BREAK2;
            `SEL_3: sel_next = SR_BREAK3;
            `SEL_6: sel_next = SR_DEBUG_STATUS;
            `SEL_7: sel_next = SR_DEBUG_CONTROL;
            default: sel_next = SR_NONE;
          endcase
        end else if (SPECIAL_GROUP == `GRP_TEST) begin
          case (SPECIAL_CODE)
            `SEL_6: sel_next = SR_TLB_COMMAND;
            `SEL_7: sel_next = SR_TLB_DATA;
            default: sel_next = SR_NONE;
          endcase
        end
        if (sel_next != SR_NONE) begin
          inv_next = 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= ST_IDLE;
      src_reg <= 3'h0;
      dst_reg <= 3'h0;
      rm_dest_reg <= 1'b0;
      byte_reg <= 1'b0;
      imm_reg <= 32'h00000000;
      cond_reg <= 1'b0;
      inv_reg <= 1'b0;
      sel_reg <= SR_NONE;
    end else begin
      state_reg <= state_next;
      src_reg <= src_next;
      dst_reg <= dst_next;
      rm_dest_reg <= rm_dest_next;
      byte_reg <= byte_next;
      imm_reg <= imm_next;
      cond_reg <= cond_next;
      inv_reg <= inv_next;
      sel_reg <= sel_next;
    end
  end

  assign OUT_VALID = (state_reg == ST_OUT);
  assign SRC_REG = src_reg;
  assign DST_REG = dst_reg;
  assign RM_IS_DEST = rm_dest_reg;
  assign BYTE_REG = byte_reg;
  assign IMM_OUT = imm_reg;
  assign COND_TRUE = cond_reg;
  assign SPECIAL_SEL = sel_reg;
  assign INVALID_OP = inv_reg;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  dir_route_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID && !OPCODE[`DIR_BIT] |=> RM_IS_DEST && SRC_REG == $past(REG_FIELD))
    else $error("direction 0 routing wrong");
  dir_swap_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID && OPCODE[`DIR_BIT] |=> !RM_IS_DEST && DST_REG == $past(REG_FIELD))
    else $error("direction 1 routing wrong");
  sign_extend_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID && OPCODE[`WIDEN_BIT] && IMM_SIZE == SZ_8 && DEST_SIZE == SZ_32
    |=> IMM_OUT == {{24{$past(IMM_IN[7])}}, $past(IMM_IN[7:0])})
    else $error("byte immediate not sign-extended");
  imm_pass_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID && !OPCODE[`WIDEN_BIT] |=> IMM_OUT == $past(IMM_IN))
    else $error("immediate altered with widen clear");
  cond_negate_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID && IS_COND && TTTN == {`CC_EQUAL, 1'b1}
    |=> COND_TRUE == !$past(FLAGS[`FLAG_ZF]))
    else $error("not-equal condition wrong");
  cond_less_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID && IS_COND && TTTN == {`CC_LESS, 1'b0}
    |=> COND_TRUE == ($past(FLAGS[`FLAG_SF]) ^ $past(FLAGS[`FLAG_OF])))
    else $error("less condition wrong");
  cond_gate_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID && !IS_COND |=> !COND_TRUE)
    else $error("condition true without conditional op");
  ctrl_sel_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID && IS_SPECIAL && SPECIAL_GROUP == `GRP_CTRL && SPECIAL_CODE == 3'h3
    |=> SPECIAL_SEL == SR_PAGE_DIR_BASE && !INVALID_OP)
    else $error("control select wrong");
  debug_sel_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID && IS_SPECIAL && SPECIAL_GROUP == `GRP_DEBUG && SPECIAL_CODE == 3'h6
    |=> SPECIAL_SEL == SR_DEBUG_STATUS)
    else $error("debug select wrong");
  test_sel_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID && IS_SPECIAL && SPECIAL_GROUP == `GRP_TEST && SPECIAL_CODE == 3'h7
    |=> SPECIAL_SEL == SR_TLB_DATA)
    else $error("test select wrong");
  byte_size_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID |=> BYTE_REG == !$past(OPCODE[`SIZE_BIT]))
    else $error("operand size wrong");
  bad_code_a: assert property (@(posedge CLK) disable iff (!RESETN)
    VALID && IS_SPECIAL && SPECIAL_GROUP == `GRP_TEST && SPECIAL_CODE == 3'h0
    |=> INVALID_OP && SPECIAL_SEL == SR_NONE)
    else $error("unlisted selector accepted");

endmodule : opcode_field_decoder

`default_nettype wire

/* dv/fetch_model.sv */
// Purpose: fetch-side model that issues decoded instruction fields
// Assumes: fields change only at the falling clock edge
// Notes: idle cycles still reshuffle fields so stale data never matches
`timescale 1ns/100ps
`default_nettype none

module fetch_model
  import opcode_field_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic slow,
  input wire logic bad,
  output logic valid,
  output logic [7:0] opcode,
  output logic [2:0] reg_field,
  output logic [2:0] rm_field,
  output logic [3:0] tttn,
  output logic is_cond,
  output logic [31:0] imm_in,
  output op_size_t imm_size,
  output op_size_t dest_size,
  output logic is_special,
  output logic [1:0] special_group,
  output logic [2:0] special_code,
  output logic [5:0] flags
);
  int seed = 32'h9977ABD7;
  int k;
  int h;

  // new random fields; destination never narrower than the immediate
  task automatic shuffle();
    {opcode, reg_field, rm_field, tttn, is_cond} = 19'($random(seed));
    {is_special, flags} = 7'($random(seed));
    k = $unsigned($random(seed)) % 3;
    h = $unsigned($random(seed)) % 6;
    imm_size = op_size_t'(k);
    dest_size = op_size_t'(k + h % (3 - k));
    imm_in = $random(seed) & (k == 0 ? 32'h0000_00FF :
      k == 1 ? 32'h0000_FFFF : 32'hFFFF_FFFF);
    special_group = 2'(h % 3);
    h = $unsigned($random(seed)) % 6;
    // only listed codes unless a test asks for bad ones
    case (special_group)
      2'h0: special_code = 3'(h % 3 == 0 ? 0 : h % 3 + 1);
      2'h1: special_code = 3'(h < 4 ? h : h + 2);
      default: special_code = 3'(6 + h % 2);
    endcase
    if (bad) begin
      {special_group, special_code} = 5'($random(seed));
    end
  endtask : shuffle

  initial begin
    valid = 1'b0;
    shuffle();
  end

  // a slow fetch path skips about half the cycles
  always @(negedge clk) begin
    shuffle();
    valid <= go && !(slow && h[0]);
  end
endmodule : fetch_model

`default_nettype wire

/* dv/test_opcode_field_decoder.sv */
// Purpose: self-checking bench for the instruction field decoder
// Assumes: one cycle answer latency, fields from the fetch model
// Notes: notes are pushed at the taking edge, popped on OUT_VALID
`timescale 1ns/100ps
`default_nettype none

module test_opcode_field_decoder;
  import opcode_field_pkg::*;
  typedef struct packed {
    int cyc;
    logic [2:0] src;
    logic [2:0] dst;
    logic rmd;
    logic byt;
    logic [31:0] imm;
    logic cnd;
    special_reg_t sel;
    logic inv;
  } note_t;
  logic clk = 1'b0, resetn, go, slow, bad, valid, is_cond, is_special;
  logic [7:0] opcode;
  logic [2:0] reg_field, rm_field, special_code, src, dst;
  logic [3:0] tttn;
  logic [31:0] imm_in, imm_out;
  logic [1:0] special_group;
  logic [5:0] flags;
  op_size_t imm_size, dest_size;
  special_reg_t sel;
  logic out_valid, rmd, byt, cnd, inv;
  int n_fail = 0, total_checks = 0, ncyc = 0;
  note_t q[$];
  note_t e;

  initial forever #2 clk = ~clk;

  fetch_model fm (.clk(clk), .go(go), .slow(slow), .bad(bad),
    .valid(valid), .opcode(opcode), .reg_field(reg_field),
    .rm_field(rm_field), .tttn(tttn), .is_cond(is_cond),
    .imm_in(imm_in), .imm_size(imm_size), .dest_size(dest_size),
    .is_special(is_special), .special_group(special_group),
    .special_code(special_code), .flags(flags));

  opcode_field_decoder dut (.CLK(clk), .RESETN(resetn), .VALID(valid),
    .OPCODE(opcode), .REG_FIELD(reg_field), .RM_FIELD(rm_field),
    .TTTN(tttn), .IS_COND(is_cond), .IMM_IN(imm_in),
    .IMM_SIZE(imm_size), .DEST_SIZE(dest_size),
    .IS_SPECIAL(is_special), .SPECIAL_GROUP(special_group),
    .SPECIAL_CODE(special_code), .FLAGS(flags), .OUT_VALID(out_valid),
    .SRC_REG(src), .DST_REG(dst), .RM_IS_DEST(rmd), .BYTE_REG(byt),
    .IMM_OUT(imm_out), .COND_TRUE(cnd), .SPECIAL_SEL(sel),
    .INVALID_OP(inv));

  // expected result of the fields now at the inputs
  function automatic note_t expect_f();
    note_t n;
    logic c, s;
    n.cyc = ncyc;
    n.src = opcode[1] ? rm_field : reg_field;
    n.dst = opcode[1] ? reg_field : rm_field;
    n.rmd = !opcode[1];
    n.byt = !opcode[0];
    s = imm_in[7];
    n.imm = imm_in;
    if (opcode[0] && imm_size == SZ_8 && dest_size == SZ_32) begin
      n.imm = {{24{s}}, imm_in[7:0]};
    end
    if (opcode[0] && imm_size == SZ_8 && dest_size == SZ_16) begin
      n.imm = {16'h0000, {8{s}}, imm_in[7:0]};
    end
    case (tttn[3:1])
      3'h0: c = flags[4];
      3'h1: c = flags[0];
      3'h2: c = flags[2];
      3'h3: c = flags[0] | flags[2];
      3'h4: c = flags[3];
      3'h5: c = flags[1];
      3'h6: c = flags[3] ^ flags[4];
      default: c = (flags[3] ^ flags[4]) | flags[2];
    endcase
    n.cnd = is_cond & (c ^ tttn[0]);
    n.sel = SR_NONE;
    if (is_special) begin
      case ({special_group, special_code})
        5'h00: n.sel = SR_CONTROL_ZERO;
        5'h02: n.sel = SR_FAULT_ADDRESS;
        5'h03: n.sel = SR_PAGE_DIR_BASE;
        5'h08, 5'h09, 5'h0A, 5'h0B:
          n.sel = special_reg_t'({2'h1, special_code[1:0]});
        5'h0E: n.sel = SR_DEBUG_STATUS;
        5'h0F: n.sel = SR_DEBUG_CONTROL;
        5'h16: n.sel = SR_TLB_COMMAND;
        5'h17: n.sel = SR_TLB_DATA;
        default: n.sel = SR_NONE;
      endcase
    end
    n.inv = is_special && n.sel == SR_NONE;
    return n;
  endfunction : expect_f

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  // the driver side notes what each taken request must give
  always @(posedge clk) begin
    if (valid === 1'b1 && resetn === 1'b1) q.push_back(expect_f());
  end

  // answers are settled by the falling edge
  always @(negedge clk) begin
    ncyc <= ncyc + 1;
    if (out_valid === 1'b1) begin
      check(32'(q.size() > 0), 32'h1);
      if (q.size() > 0) begin
        e = q.pop_front();
        // ncyc moves by NBA, so no falling edge is counted between the
        // taking edge and this one: equal counts mean one cycle latency
        check(32'(ncyc), 32'(e.cyc));
        check(32'({src, dst, rmd}), 32'({e.src, e.dst, e.rmd}));
        check(32'(byt), 32'(e.byt));
        check(imm_out, e.imm);
        check(32'(cnd), 32'(e.cnd));
        check(32'(sel), 32'(e.sel));
        check(32'(inv), 32'(e.inv));
      end
    end
  end

  task automatic run(input logic s, input logic b, input int n,
                     input string name);
    slow <= s;
    bad <= b;
    go <= 1'b1;
    repeat (n) @(negedge clk);
    go <= 1'b0;
    repeat (4) @(negedge clk);
    check(32'(q.size()), 32'h0);
    $display("test %s ended, checks %0d", name, total_checks);
  endtask : run

  initial begin
    {resetn, go, slow, bad} = 4'h0;
    repeat (16) @(negedge clk);
    resetn <= 1'b1;
    run(1'b0, 1'b0, 600, "back_to_back");
    run(1'b1, 1'b0, 400, "stalling_fetch");
    run(1'b0, 1'b1, 400, "unlisted_selectors");
    run(1'b0, 1'b0, 200, "second_pass");
    // a reset between runs must clear the valid, invalid, condition and select outputs
    resetn <= 1'b0;
    repeat (2) @(negedge clk);
    check(32'({out_valid, inv, cnd, sel}), 32'h0);
    resetn <= 1'b1;
    run(1'b1, 1'b0, 100, "after_reset");
    print_verdict();
  end

  // the tests need under 1800 cycles; give them twice that
  initial begin
    #(4 * 3600);
    n_fail++;
    print_verdict();
  end
endmodule : test_opcode_field_decoder

`default_nettype wire
